//--- logic/aer_control_vc_capability_regs.v
// Error control word, header capture and channel capability registers,
// reached as an AHB-Lite slave with zero wait states.
// Assumes a single master, word transfers and synchronous pin inputs.
`timescale 1ns/10ps
`default_nettype none
`include "aer_vc_consts.vh"

// Notes on behaviour
// - Sticky read-only first error index, reset zero
// - Bit 5 reads one: CRC generation capable
// - Bit 6 sticky writable CRC generation enable
// - Bit 7 reads one: CRC check capable
// - Bit 8 sticky writable CRC check enable
// - Four sticky read-only header capture words
// - First header byte in top byte
// - Capability header identifier reads 0002h
// - Capability version reads 1h
// - Next capability pointer reads 20Ch
// - Extra channel count follows strap, autoload
// - Low priority group count, reset zero, autoload
// - Reference tick field reads 00b
// - Arbitration entry size field reads 10b
// - Arbitration capability 03h when extra channel count bit 0 set
// - Arbitration capability independent of group count
// - Arbitration table offset 03h when extra channel count bit 0 set
// - Masked correctable errors never captured
module aer_control_vc_capability_regs
(
  input  wire        clock_in,
  input  wire        nrst_in,
  input  wire        sticky_nrst_in,
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output wire        hreadyout_out,
  output wire        hresp_out,
  output reg  [31:0] hrdata_out,
  input  wire        second_channel_strap_in,
  input  wire        autoload_valid_in,
  input  wire [2:0]  autoload_ext_count_in,
  input  wire [2:0]  autoload_low_priority_in,
  input  wire        uncorr_event_in,
  input  wire [4:0]  uncorr_index_in,
  input  wire        corr_event_in,
  input  wire        corr_masked_in,
  input  wire [7:0]  header_byte0_in,
  input  wire [127:0] header_in,
  input  wire        uncorr_status_clear_in,
  output reg         ecrc_gen_enable_out,
  output reg         ecrc_check_enable_out,
  output reg         header_logged_out
);

  // Sticky state
  reg  [4:0]   first_err_ptr;
  reg  [127:0] header_log;

  // Non-sticky state
  reg  [2:0]   ext_count;
  reg  [2:0]   low_priority_channel_group;
  reg          strap_taken;
  reg          wr_pending;
  reg  [11:0]  wr_addr;

  // Next values
  reg  [31:0]  next_rdata;
  reg  [4:0]   next_first_err_ptr;
  reg  [127:0] next_header_log;
  reg          next_header_logged;
  reg          next_gen_enable;
  reg          next_check_enable;
  reg  [2:0]   next_ext_count;
  reg  [2:0]   next_low_priority;

  // Bus decode
  wire         access;
  wire         rd_access;
  wire         wr_access;
  wire [11:0]  addr;
  wire         ctrl_write;

  // Error capture
  wire         corr_capture;
  wire         uncorr_capture;
  wire         capture;
  wire [127:0] header_ordered;

  // Capability fields
  wire [7:0]   sixteen_byte_unit;
  wire [7:0]   arb_cap;

  // Register words as software sees them
  wire [31:0]  ctrl_word;
  wire [31:0]  hdr_word0;
  wire [31:0]  hdr_word1;
  wire [31:0]  hdr_word2;
  wire [31:0]  hdr_word3;
  wire [31:0]  vc_header_word;
  wire [31:0]  chan_cap1_word;
  wire [31:0]  chan_cap2_word;
  wire [31:0]  event_word;

  // Zero wait states and an OKAY response on every transfer
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // A transfer is taken only on NONSEQ or SEQ with the bus ready
  assign access    = hsel_in & htrans_in[1] & hready_in;
  assign rd_access = access & ~hwrite_in;
  assign wr_access = access & hwrite_in;

  // Byte lanes are ignored: only whole words exist here
  assign addr = {haddr_in[11:2], 2'b00};

  // Write data comes one cycle after its address, so the decode uses the
  // address latched in the address phase
  assign ctrl_write = wr_pending & (wr_addr == `ERR_CAP_CTRL_ADDR);

  // Masked correctable events never reach the log
  assign corr_capture   = corr_event_in & ~corr_masked_in;
  assign uncorr_capture = uncorr_event_in;

  // The log is free only while nothing is held, so the first error wins
  assign capture = ~header_logged_out & (uncorr_capture | corr_capture);

  // First header byte on the wire goes to the top byte of word 0
  assign header_ordered = {header_in[127:32], header_byte0_in, header_in[23:0]};

  // Pointer follows only uncorrectable errors, loaded together with the log
  always @*
  begin
    next_first_err_ptr = first_err_ptr;
    if (capture && uncorr_capture)
    begin
      next_first_err_ptr = uncorr_index_in;
    end
  end

  always @*
  begin
    next_header_log = header_log;
    if (capture)
    begin
      next_header_log = header_ordered;
    end
  end

  // Capture outranks clear, but a held log blocks capture, so an error in the clear cycle is lost
  always @*
  begin
    next_header_logged = header_logged_out;
    if (capture)
    begin
      next_header_logged = 1'b1;
    end
    else if (uncorr_status_clear_in)
    begin
      next_header_logged = 1'b0;
    end
  end

  // Only the two enable bits are writable; the rest of the word is ignored
  always @*
  begin
    next_gen_enable   = ecrc_gen_enable_out;
    next_check_enable = ecrc_check_enable_out;
    if (ctrl_write)
    begin
      next_gen_enable   = hwdata_in[`ECRC_GEN_EN_BIT];
      next_check_enable = hwdata_in[`ECRC_CHK_EN_BIT];
    end
  end

  // Sticky state: only the fundamental reset clears it
  always @(posedge clock_in)
  begin
    if (!sticky_nrst_in)
    begin
      first_err_ptr <= `FIRST_ERR_PTR_RESET;
    end
    else
    begin
      first_err_ptr <= next_first_err_ptr;
    end
  end

  always @(posedge clock_in)
  begin
    if (!sticky_nrst_in)
    begin
      header_log <= 128'h0;
    end
    else
    begin
      header_log <= next_header_log;
    end
  end

  always @(posedge clock_in)
  begin
    if (!sticky_nrst_in)
    begin
      header_logged_out <= 1'b0;
    end
    else
    begin
      header_logged_out <= next_header_logged;
    end
  end

  always @(posedge clock_in)
  begin
    if (!sticky_nrst_in)
    begin
      ecrc_gen_enable_out   <= 1'b0;
      ecrc_check_enable_out <= 1'b0;
    end
    else
    begin
      ecrc_gen_enable_out   <= next_gen_enable;
      ecrc_check_enable_out <= next_check_enable;
    end
  end

  // Bus state: address phase latched for the data phase
  always @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      wr_pending <= 1'b0;
      wr_addr    <= 12'h000;
    end
    else
    begin
      wr_pending <= wr_access;
      wr_addr    <= addr;
    end
  end

  // Strap is taken once at the first edge after reset; autoload may then
  // override it, but a later strap change is ignored until the next reset
  always @*
  begin
    next_ext_count    = ext_count;
    next_low_priority = low_priority_channel_group;
    if (!strap_taken)
    begin
      next_ext_count = {2'b00, second_channel_strap_in};
    end
    else if (autoload_valid_in)
    begin
      next_ext_count    = autoload_ext_count_in;
      next_low_priority = autoload_low_priority_in;
    end
  end

  always @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      strap_taken                <= 1'b0;
      ext_count                  <= 3'h0;
      low_priority_channel_group <= 3'h0;
    end
    else
    begin
      strap_taken                <= 1'b1;
      ext_count                  <= next_ext_count;
      low_priority_channel_group <= next_low_priority;
    end
  end

  // Capability 2 follows the live channel count, so autoload shows at once
  assign arb_cap           = ext_count[0] ? `VC_ARB_CAP_ON : 8'h00;
  assign sixteen_byte_unit = ext_count[0] ? `VC_ARB_TABLE_ON : 8'h00;

  // Reserved ranges are tied low in every word
  assign ctrl_word = {23'h0,
                      ecrc_check_enable_out,
                      1'b1,
                      ecrc_gen_enable_out,
                      1'b1,
                      first_err_ptr};

  assign hdr_word0 = header_log[31:0];
  assign hdr_word1 = header_log[63:32];
  assign hdr_word2 = header_log[95:64];
  assign hdr_word3 = header_log[127:96];

  assign vc_header_word = {`VC_NEXT_CAP_PTR,
                           `VC_CAP_VERSION,
                           `VC_EXT_CAP_ID};

  assign chan_cap1_word = {20'h0,
                           `ARB_ENTRY_4BIT,
                           `REF_CLOCK_100NS,
                           1'b0,
                           low_priority_channel_group,
                           1'b0,
                           ext_count};

  assign chan_cap2_word = {sixteen_byte_unit,
                           16'h0,
                           arb_cap};

  // Extra status word: lets software see whether the log is held
  assign event_word = {31'h0, header_logged_out};

  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (addr)
      `ERR_CAP_CTRL_ADDR:
      begin
        next_rdata = ctrl_word;
      end
      `HDR_CAPTURE0_ADDR:
      begin
        next_rdata = hdr_word0;
      end
      `HDR_CAPTURE1_ADDR:
      begin
        next_rdata = hdr_word1;
      end
      `HDR_CAPTURE2_ADDR:
      begin
        next_rdata = hdr_word2;
      end
      `HDR_CAPTURE3_ADDR:
      begin
        next_rdata = hdr_word3;
      end
      `VC_CAP_HEADER_ADDR:
      begin
        next_rdata = vc_header_word;
      end
      `PORT_CHAN_CAP1_ADDR:
      begin
        next_rdata = chan_cap1_word;
      end
      `PORT_CHAN_CAP2_ADDR:
      begin
        next_rdata = chan_cap2_word;
      end
      `ERROR_EVENT_ADDR:
      begin
        next_rdata = event_word;
      end
      default:
      begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data is launched at the address phase edge and stands through the
  // data phase; it then holds until the next read
  always @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      hrdata_out <= 32'h0000_0000;
    end
    else if (rd_access)
    begin
      hrdata_out <= next_rdata;
    end
  end

  // Unused bus qualifiers: only single word transfers are supported
  wire unused_size;
  assign unused_size = ^{hsize_in, haddr_in[31:12], haddr_in[1:0], htrans_in[0]};

endmodule // aer_control_vc_capability_regs
`default_nettype wire

//--- shared/aer_vc_consts.vh
// Offsets, field positions, reset values and fixed codes of the error control,
// header capture and channel capability registers.
// Assumes inclusion by bare name from the design files.
`ifndef AER_VC_CONSTS_VH
`define AER_VC_CONSTS_VH

`define ERR_CAP_CTRL_ADDR     12'h118
`define HDR_CAPTURE0_ADDR     12'h11C
`define HDR_CAPTURE1_ADDR     12'h120
`define HDR_CAPTURE2_ADDR     12'h124
`define HDR_CAPTURE3_ADDR     12'h128
`define VC_CAP_HEADER_ADDR    12'h140
`define PORT_CHAN_CAP1_ADDR   12'h144
`define PORT_CHAN_CAP2_ADDR   12'h148
`define ERROR_EVENT_ADDR      12'h180

`define FIRST_ERR_PTR_RESET   5'h00
`define ECRC_GEN_CAP_BIT      5
`define ECRC_GEN_EN_BIT       6
`define ECRC_CHK_CAP_BIT      7
`define ECRC_CHK_EN_BIT       8

`define VC_EXT_CAP_ID         16'h0002
`define VC_CAP_VERSION        4'h1
`define VC_NEXT_CAP_PTR       12'h20C
`define REF_CLOCK_100NS       2'h0
`define ARB_ENTRY_4BIT        2'h2
`define VC_ARB_CAP_ON         8'h03
`define VC_ARB_TABLE_ON       8'h03

`endif

//--- tb/aer_regs_properties.sv
// Checker on the slave ports: fixed fields, enables, capture.
// Bound into every instance of the register slice.
`timescale 1ns/10ps
`default_nettype none
module aer_regs_props
(
  input wire logic        clock_in,
  input wire logic        nrst_in,
  input wire logic        sticky_nrst_in,
  input wire logic        hsel_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [1:0]  htrans_in,
  input wire logic [31:0] haddr_in,
  input wire logic [31:0] hwdata_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        corr_event_in,
  input wire logic        corr_masked_in,
  input wire logic        uncorr_event_in,
  input wire logic        ecrc_gen_enable_out,
  input wire logic        ecrc_check_enable_out,
  input wire logic        header_logged_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in || !sticky_nrst_in);
  wire [9:0] a = haddr_in[11:2];
  wire rd = hsel_in & htrans_in[1] & hready_in & !hwrite_in;
  wire wr = hsel_in & htrans_in[1] & hready_in & hwrite_in & a == 10'h046;
  AST_GEN: assert property (wr |=> ##1 ecrc_gen_enable_out == $past(hwdata_in[6]))
    else $error("gen enable");
  AST_CHK: assert property (wr |=> ##1 ecrc_check_enable_out == $past(hwdata_in[8]))
    else $error("check enable");
  AST_CTRL: assert property (rd && a == 10'h046 |=> hrdata_out[31:9] == 23'h0
    && hrdata_out[7] && hrdata_out[5]) else $error("control read");
  AST_HDR: assert property (rd && a == 10'h050 |=> hrdata_out == 32'h20C10002)
    else $error("cap header");
  AST_CAP1: assert property (rd && a == 10'h051 |=> (hrdata_out & 32'hFFFFFF88) == 32'h800)
    else $error("cap one");
  AST_CAP2: assert property (rd && a == 10'h052 |=> hrdata_out[23:8] == 16'h0
    && hrdata_out[31:24] == hrdata_out[7:0]) else $error("cap two");
  AST_NONE: assert property (rd && a == 10'h07C |=> hrdata_out == 32'h0)
    else $error("unmapped");
  AST_LOG: assert property ($rose(header_logged_out) |->
    $past(uncorr_event_in || corr_event_in && !corr_masked_in)) else $error("capture");
  cover property (wr);
  cover property ($rose(header_logged_out));
  cover property (rd && a == 10'h052);
endmodule // aer_regs_props
bind aer_control_vc_capability_regs aer_regs_props aer_regs_props_inst (.*);
`default_nettype wire

//--- tb/tb.sv
// Bench: bus reads and writes, error events, strap and autoload.
// Drives the slave itself; hready_in follows hreadyout_out.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clock_in = 0, nrst_in = 0, sticky_nrst_in = 0, hsel_in = 0, hwrite_in = 0;
  logic hready_in, hreadyout_out, hresp_out, ecrc_gen_enable_out, ecrc_check_enable_out;
  logic second_channel_strap_in = 1, autoload_valid_in = 0, uncorr_event_in = 0;
  logic corr_event_in = 0, corr_masked_in = 1, uncorr_status_clear_in = 0, header_logged_out;
  logic [1:0] htrans_in = 0;
  logic [2:0] hsize_in = 3'h2, autoload_ext_count_in = 0, autoload_low_priority_in = 0;
  logic [4:0] uncorr_index_in = 0;
  logic [7:0] header_byte0_in = 8'hA0;
  logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, r;
  logic [127:0] header_in = 128'hD3D2D1D0_C3C2C1C0_B3B2B1B0_A0A1A2A3;
  int fail_count = 0, check_count = 0;
  assign hready_in = hreadyout_out;
  always #10 clock_in = ~clock_in;
  aer_control_vc_capability_regs aer_control_vc_capability_regs_inst (.*);
  task results;
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task clk(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task wt;
    repeat (50)
    begin
      clk(1);
      if (hreadyout_out === 1'b1) return;
    end
    fail_count++;
    results;
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    {hsel_in, htrans_in, hwrite_in, haddr_in} <= {3'h6, w, 20'h0, a};
    wt;
    {hsel_in, htrans_in, hwdata_in} <= {3'h0, d};
    wt;
    r = hrdata_out;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(r, e);
  endtask
  // Bit 1 is the sticky reset, bit 0 the ordinary one
  task rst(input logic [1:0] m);
    {sticky_nrst_in, nrst_in} <= m;
    clk(1);
    {sticky_nrst_in, nrst_in} <= 2'h3;
    clk(2);
  endtask
  task test_control;
    rc(12'h118, 32'hA0);
    rc(12'h140, 32'h20C10002);
    rc(12'h144, 32'h801);
    rc(12'h148, 32'h03000003);
    rc(12'h1F0, 0);
    chk(hresp_out, 0);
    bus(1, 12'h118, 32'hFFFFFFFF);
    clk(1);
    chk(ecrc_gen_enable_out, 1);
    chk(ecrc_check_enable_out, 1);
    rc(12'h118, 32'h1E0);
    rst(2'h2);
    rc(12'h118, 32'h1E0);
    rst(2'h1);
    rc(12'h118, 32'hA0);
    chk(ecrc_gen_enable_out, 0);
    $display("control done");
  endtask
  task test_capture;
    {corr_event_in, uncorr_index_in} <= 6'h33;
    clk(1);
    {corr_event_in, uncorr_event_in} <= 2'h1;
    clk(1);
    {header_in, uncorr_index_in} <= {~header_in, 5'h04};
    clk(1);
    uncorr_event_in <= 0;
    clk(1);
    chk(header_logged_out, 1);
    rc(12'h180, 1);
    rc(12'h118, 32'hB3);
    for (int i = 0; i < 4; i++) rc(12'h11C + 12'(4 * i), ~header_in[32 * i +: 32]);
    uncorr_status_clear_in <= 1;
    clk(1);
    uncorr_status_clear_in <= 0;
    clk(2);
    chk(header_logged_out, 0);
    rc(12'h180, 0);
    $display("capture done");
  endtask
  task test_channel;
    second_channel_strap_in <= 0;
    rst(2'h2);
    rc(12'h144, 32'h800);
    rc(12'h148, 0);
    {autoload_valid_in, autoload_ext_count_in, autoload_low_priority_in} <= 7'h5A;
    clk(1);
    autoload_valid_in <= 0;
    rc(12'h144, 32'h823);
    rc(12'h148, 32'h03000003);
    $display("channel done");
  endtask
  initial
  begin
    clk(19);
    rst(2'h0);
    test_control;
    test_capture;
    test_channel;
    results;
  end
endmodule // tb
`default_nettype wire
